// ---- flash_query_host.sv ----
// flash_query_host.sv - host controller that drives a parallel nor flash through its pins
// assumes: one 125 MHz clock, flash inputs synchronous to it, software on a simple strobe port
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`include "fq_map.svh"

// Overview of operation
// R1 - query word 27h must read size exponent 18h, 19h or 1Ah by density
// R2 - words 28h/29h read 0002h/0000h, 2Ah/2Bh read 0005h/0000h
// R3 - word 2Ch reads 0001h, one uniform erase region
// R4 - words 2Dh-30h hold region one by density; 31h-3Ch read zero
// R5 - words 40h-44h read ascii PRI then version digits 1 and 3
// R6 - word 45h reads 0010h, unlock required, technology code
// R7 - word 46h reads 0002h, word 47h reads 0001h
// R8 - word 49h reads 0008h; 48h, 4Ah, 4Bh read zero
// R9 - word 4Ch reads 0002h, eight word page
// R10 - words 4Dh/4Eh read 00B5h/00C5h acceleration supply limits
// R11 - word 4Fh reads 04h for bottom, 05h for top write protect
// R12 - word 50h reads 0001h, program suspend supported
// R13 - host writes only valid command cycles in order; reset recovers otherwise
// R14 - address taken on later falling strobe, data on earlier rising strobe
// R15 - flash reads array after power up and after embedded operations finish
// R16 - erase suspend gives suspend read mode, kept after program in suspend
// R17 - reset returns to read or suspend read; its address is ignored
// R18 - reset aborts erase sequence; ignored once erasing runs
// R19 - reset aborts program sequence; ignored once programming runs
// R20 - reset leaves autoselect, back to read or suspend read
// R21 - on timeout status bit the host writes reset
// R22 - on buffer abort status bit the host writes the abort reset sequence
// R23 - query entered by 98h at 55h from read or autoselect; reset leaves
// R24 - query data sit in the low byte, upper byte zero
module flash_query_host #(
	parameter int ADDR_W = `FQ_ADDR_W_DEF
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] sw_addr,
	input wire logic [31:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [31:0] sw_rdata,
	output fq_pkg::strobe_t flash_ctl,
	output logic [ADDR_W-1:0] flash_addr,
	output logic [15:0] flash_dq_o,
	output logic flash_dq_oe,
	input wire logic [15:0] flash_dq_i
);
	import fq_pkg::*;

	function automatic int cyc_up(input int ns);
		int c;
		c = (ns * `FQ_CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int SU_CYC = cyc_up(`FQ_T_SU_NS);
	localparam int WP_CYC = cyc_up(`FQ_T_WP_NS);
	localparam int ACC_CYC = cyc_up(`FQ_T_ACC_NS);
	localparam int HD_CYC = cyc_up(`FQ_T_HD_NS);

	if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_width
		$error("ADDR_W must be 12 to 32");
	end

	function automatic cyc_t cycle_of(input op_t op, input logic [5:0] step, input logic [31:0] a,
		input logic [15:0] d);
		cyc_t c;
		c = '{write: 1'b0, addr: a, data: d};
		case (op)
			OP_WR: c.write = 1'b1;
			OP_RST: begin
				c.write = 1'b1;
				c.data = {8'h00, `FQ_RESET_CMD}; // R17
			end
			OP_QRY: begin
				c.write = 1'b1;
				c.addr = `FQ_QUERY_ADDR; // R23
				c.data = {8'h00, `FQ_QUERY_CMD};
			end
			OP_CHK: c.addr = `FQ_QRY_FIRST + {26'h0, step};
			OP_ABT: begin
				c.write = 1'b1;
				case (step) // R22
					6'h00: c = '{write: 1'b1, addr: `FQ_UNLOCK1_ADDR, data: {8'h00, `FQ_UNLOCK1_DATA}};
					6'h01: c = '{write: 1'b1, addr: `FQ_UNLOCK2_ADDR, data: {8'h00, `FQ_UNLOCK2_DATA}};
					default: c = '{write: 1'b1, addr: `FQ_UNLOCK1_ADDR, data: {8'h00, `FQ_RESET_CMD}};
				endcase
			end
			default: c.write = 1'b0;
		endcase
		return c;
	endfunction

	// bit 8 marks a defined table entry
	function automatic logic [8:0] expect_of(input logic [6:0] a, input logic [1:0] dens, input logic wp_top);
		logic [7:0] v;
		logic k;
		v = 8'h00;
		k = 1'b1;
		case (a)
			7'h27: v = 8'h18 + {6'h00, dens}; // R1
			7'h28: v = 8'h02; // R2
			7'h2a: v = 8'h05; // R2
			7'h2c: v = 8'h01; // R3
			7'h2d: v = (dens == 2'h0) ? 8'h7f : 8'hff; // R4
			7'h2e: v = (dens == 2'h2) ? 8'h01 : 8'h00; // R4
			7'h30: v = 8'h02; // R4
			7'h3d, 7'h3e, 7'h3f: k = 1'b0;
			7'h40: v = 8'h50; // R5
			7'h41: v = 8'h52; // R5
			7'h42: v = 8'h49; // R5
			7'h43: v = 8'h31; // R5
			7'h44: v = 8'h33; // R5
			7'h45: v = 8'h10; // R6
			7'h46: v = 8'h02; // R7
			7'h47: v = 8'h01; // R7
			7'h49: v = 8'h08; // R8
			7'h4c: v = 8'h02; // R9
			7'h4d: v = 8'hb5; // R10
			7'h4e: v = 8'hc5; // R10
			7'h4f: v = wp_top ? 8'h05 : 8'h04; // R11
			7'h50: v = 8'h01; // R12
			default: v = 8'h00; // R8
		endcase
		return {k, v};
	endfunction

	state_t st_q;
	op_t op_q, nop_c, op_in;
	mode_t mode_q;
	logic [5:0] step_q, nstep_c;
	logic [7:0] tmr_q;
	logic [31:0] addr_reg_q;
	logic [15:0] wdata_q, rd_q, rd0_q;
	logic [2:0] cfg_q;
	logic [31:0] fail_q;
	logic susp_q, dev_busy_q, mismatch_q, refused_q, timeout_q, abort_q;
	logic cmd_wr, refuse_c, start, last_c, toggled, redirect, go_on, done, load, cap, chk_cap, chk_bad;
	logic [8:0] exp_c;
	cyc_t ncyc;

	assign op_in = op_t'(sw_wdata[2:0]);
	assign cmd_wr = sw_wr && sw_addr == `FQ_REG_CMD;
	assign toggled = rd0_q[`FQ_DQ_TOGGLE] ^ rd_q[`FQ_DQ_TOGGLE];
	assign exp_c = expect_of(flash_addr[6:0], cfg_q[`FQ_CFG_DENS_LSB +: 2], cfg_q[`FQ_CFG_WPTOP]);
	assign cap = st_q == S_STROBE && tmr_q == 8'h01 && !flash_dq_oe;
	assign chk_cap = cap && op_q == OP_CHK && exp_c[8];
	assign chk_bad = flash_dq_i != {8'h00, exp_c[7:0]}; // R24

	always_comb begin
		refuse_c = 1'b0;
		if (st_q != S_IDLE || sw_wdata[2:0] == 3'h7)
			refuse_c = 1'b1;
		else if (op_in == OP_QRY && mode_q != M_READ && mode_q != M_AUTOSEL)
			refuse_c = 1'b1; // R23
		else if (op_in == OP_RST && dev_busy_q)
			refuse_c = 1'b1; // R19
		start = cmd_wr && !refuse_c;
		case (op_q)
			OP_ABT: last_c = step_q == 6'h02;
			OP_POLL: last_c = step_q == 6'h01;
			OP_CHK: last_c = step_q == `FQ_CHK_LAST;
			default: last_c = 1'b1;
		endcase
		// judge the poll only once both reads are in
		redirect = st_q == S_NEXT && op_q == OP_POLL && last_c && toggled
			&& (rd_q[`FQ_DQ_TIMEOUT] || rd_q[`FQ_DQ_BUFABORT]);
		go_on = !last_c || redirect;
		done = st_q == S_NEXT && !go_on;
		load = (st_q == S_IDLE && start) || (st_q == S_NEXT && go_on);
		if (st_q == S_IDLE) begin
			nop_c = op_in;
			nstep_c = 6'h00;
		end else if (redirect) begin
			nop_c = rd_q[`FQ_DQ_TIMEOUT] ? OP_RST : OP_ABT; // R21
			nstep_c = 6'h00;
		end else begin
			nop_c = op_q;
			nstep_c = step_q + 6'h01;
		end
		ncyc = cycle_of(nop_c, nstep_c, addr_reg_q, wdata_q);
	end

	// cycle sequencer
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_q <= S_IDLE;
			op_q <= OP_WR;
			step_q <= 6'h00;
			tmr_q <= 8'h00;
		end else begin
			case (st_q)
				S_IDLE, S_NEXT: begin
					if (load) begin
						st_q <= S_SETUP;
						op_q <= nop_c;
						step_q <= nstep_c;
						tmr_q <= 8'(SU_CYC);
					end else
						st_q <= S_IDLE;
				end
				S_SETUP: begin
					if (tmr_q == 8'h01) begin
						st_q <= S_STROBE;
						tmr_q <= flash_dq_oe ? 8'(WP_CYC) : 8'(ACC_CYC);
					end else
						tmr_q <= tmr_q - 8'h01;
				end
				S_STROBE: begin
					if (tmr_q == 8'h01) begin
						st_q <= S_HOLD;
						tmr_q <= 8'(HD_CYC);
					end else
						tmr_q <= tmr_q - 8'h01;
				end
				S_HOLD: begin
					if (tmr_q == 8'h01)
						st_q <= S_NEXT;
					else
						tmr_q <= tmr_q - 8'h01;
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	// pins: address settles before the write strobe falls, data held past its rise
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			flash_ctl <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
			flash_addr <= '0;
			flash_dq_o <= 16'h0000;
			flash_dq_oe <= 1'b0;
		end else begin
			if (load) begin
				flash_addr <= ncyc.addr[ADDR_W-1:0]; // R14
				flash_dq_o <= ncyc.data;
				flash_dq_oe <= ncyc.write;
				flash_ctl.ce_n <= 1'b0;
			end
			if (st_q == S_SETUP && tmr_q == 8'h01) begin
				if (flash_dq_oe)
					flash_ctl.we_n <= 1'b0;
				else
					flash_ctl.oe_n <= 1'b0;
			end
			if (st_q == S_STROBE && tmr_q == 8'h01) begin
				flash_ctl.we_n <= 1'b1; // R14
				flash_ctl.oe_n <= 1'b1;
			end
			if (st_q == S_HOLD && tmr_q == 8'h01) begin
				flash_ctl.ce_n <= 1'b1;
				flash_dq_oe <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rd_q <= 16'h0000;
			rd0_q <= 16'h0000;
			fail_q <= 32'h0;
		end else if (cap) begin
			rd_q <= flash_dq_i;
			rd0_q <= rd_q;
			if (chk_cap && chk_bad)
				fail_q <= {9'h000, flash_addr[6:0], flash_dq_i};
		end
	end

	// shadow of the flash mode
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mode_q <= M_READ; // R15
			susp_q <= 1'b0;
			dev_busy_q <= 1'b0;
		end else if (done) begin
			case (op_q)
				OP_RST, OP_ABT: begin
					mode_q <= susp_q ? M_SUSP : M_READ; // R20
					dev_busy_q <= 1'b0;
				end
				OP_QRY: mode_q <= M_QUERY;
				OP_POLL: begin
					dev_busy_q <= toggled; // R18
					if (!toggled)
						mode_q <= susp_q ? M_SUSP : M_READ; // R16
				end
				OP_WR: begin
					case (wdata_q[7:0])
						`FQ_AUTOSEL_CMD: mode_q <= M_AUTOSEL;
						`FQ_QUERY_CMD: if (addr_reg_q == `FQ_QUERY_ADDR && (mode_q == M_READ || mode_q == M_AUTOSEL))
							mode_q <= M_QUERY; // R23
						`FQ_RESET_CMD: if (!dev_busy_q) mode_q <= susp_q ? M_SUSP : M_READ; // R17
						`FQ_SUSPEND_CMD: begin
							susp_q <= 1'b1;
							mode_q <= M_SUSP; // R16
							dev_busy_q <= 1'b0;
						end
						`FQ_RESUME_CMD: begin
							susp_q <= 1'b0;
							mode_q <= M_READ;
							dev_busy_q <= 1'b1;
						end
						default: mode_q <= mode_q;
					endcase
				end
				default: mode_q <= mode_q;
			endcase
		end
	end

	logic clr;
	assign clr = sw_wr && sw_addr == `FQ_REG_STATUS;

	// sticky flags, write one to clear, a new event wins
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mismatch_q <= 1'b0;
			refused_q <= 1'b0;
			timeout_q <= 1'b0;
			abort_q <= 1'b0;
		end else begin
			mismatch_q <= (chk_cap && chk_bad) || (mismatch_q && !(clr && sw_wdata[`FQ_ST_MISMATCH]));
			refused_q <= (cmd_wr && refuse_c) || (refused_q && !(clr && sw_wdata[`FQ_ST_REFUSED]));
			timeout_q <= (redirect && rd_q[`FQ_DQ_TIMEOUT]) || (timeout_q && !(clr && sw_wdata[`FQ_ST_TIMEOUT]));
			abort_q <= (redirect && !rd_q[`FQ_DQ_TIMEOUT]) || (abort_q && !(clr && sw_wdata[`FQ_ST_ABORT]));
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			addr_reg_q <= 32'h0;
			wdata_q <= 16'h0000;
			cfg_q <= `FQ_CFG_RST;
		end else if (sw_wr) begin
			if (sw_addr == `FQ_REG_ADDR)
				addr_reg_q <= sw_wdata;
			if (sw_addr == `FQ_REG_WDATA)
				wdata_q <= sw_wdata[15:0];
			if (sw_addr == `FQ_REG_CONFIG)
				cfg_q <= sw_wdata[2:0];
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			sw_rdata <= 32'h0;
		else if (sw_rd) begin
			case (sw_addr)
				`FQ_REG_ADDR: sw_rdata <= addr_reg_q;
				`FQ_REG_WDATA: sw_rdata <= {16'h0000, wdata_q};
				`FQ_REG_STATUS: sw_rdata <= {23'h0, susp_q, mode_q, dev_busy_q, abort_q, timeout_q,
					refused_q, mismatch_q, st_q != S_IDLE};
				`FQ_REG_RDATA: sw_rdata <= {16'h0000, rd_q};
				`FQ_REG_CONFIG: sw_rdata <= {29'h0, cfg_q};
				`FQ_REG_FAIL: sw_rdata <= fail_q;
				default: sw_rdata <= 32'h0;
			endcase
		end else
			sw_rdata <= 32'h0;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_query_cmd_pins: assert property ((op_q == OP_QRY && $fell(flash_ctl.we_n)) |-> // R23
		(32'(flash_addr) == `FQ_QUERY_ADDR && flash_dq_o == {8'h00, `FQ_QUERY_CMD}))
		else $error("query entry cycle wrong");
	a_data_held_rise: assert property ($rose(flash_ctl.we_n) |-> // R14
		(flash_dq_oe && !flash_ctl.ce_n && $stable(flash_dq_o)))
		else $error("data not held at write strobe rise");
	a_addr_held_strobe: assert property ((!flash_ctl.we_n || !flash_ctl.oe_n) |-> // R14
		($stable(flash_addr) && !flash_ctl.ce_n))
		else $error("address moved during strobe");
	a_reset_mode_back: assert property ((done && op_q == OP_RST) |=> // R17
		(mode_q == (susp_q ? M_SUSP : M_READ) && !dev_busy_q))
		else $error("reset did not restore mode");
	a_query_refused: assert property ((cmd_wr && st_q == S_IDLE && op_in == OP_QRY // R23
		&& (mode_q == M_SUSP || mode_q == M_QUERY)) |=> (st_q == S_IDLE && refused_q))
		else $error("query entry not refused");
	a_busy_reset_ignored: assert property ((cmd_wr && st_q == S_IDLE && op_in == OP_RST && dev_busy_q) // R18
		|=> (st_q == S_IDLE && refused_q) ##1 flash_ctl.ce_n)
		else $error("reset sent while flash busy");
	a_timeout_reset: assert property ((redirect && rd_q[`FQ_DQ_TIMEOUT]) |=> // R21
		(op_q == OP_RST && st_q == S_SETUP && timeout_q) ##[1:40] $fell(flash_ctl.we_n))
		else $error("timeout not followed by reset");
	a_abort_sequence: assert property ((op_q == OP_ABT && step_q == 6'h01 && $fell(flash_ctl.we_n)) |-> // R22
		(32'(flash_addr) == `FQ_UNLOCK2_ADDR && flash_dq_o == {8'h00, `FQ_UNLOCK2_DATA}))
		else $error("abort sequence second cycle wrong");
	a_size_code: assert property ((chk_cap && flash_addr[6:0] == 7'h27 // R1
		&& flash_dq_i != {8'h00, 8'h18 + {6'h00, cfg_q[1:0]}}) |=> mismatch_q)
		else $error("size code mismatch not flagged");
	a_upper_byte_zero: assert property ((chk_cap && flash_dq_i[15:8] != 8'h00) |=> // R24
		(mismatch_q && fail_q[15:0] == $past(flash_dq_i)))
		else $error("upper byte not flagged");
endmodule // flash_query_host

// ---- fq_map.svh ----
// fq_map.svh - offsets, field positions, reset values, flash commands and timing figures
// assumes: included by bare name from the controller and the testbench
`ifndef FQ_MAP_SVH
`define FQ_MAP_SVH

// software register offsets (byte addresses)
`define FQ_REG_ADDR 8'h00
`define FQ_REG_WDATA 8'h04
`define FQ_REG_CMD 8'h08
`define FQ_REG_STATUS 8'h0c
`define FQ_REG_RDATA 8'h10
`define FQ_REG_CONFIG 8'h14
`define FQ_REG_FAIL 8'h18

// status fields
`define FQ_ST_BUSY 0
`define FQ_ST_MISMATCH 1
`define FQ_ST_REFUSED 2
`define FQ_ST_TIMEOUT 3
`define FQ_ST_ABORT 4
`define FQ_ST_DEVBUSY 5
`define FQ_ST_MODE_LSB 6
`define FQ_ST_SUSP 8

// config fields and reset value
`define FQ_CFG_DENS_LSB 0
`define FQ_CFG_WPTOP 2
`define FQ_CFG_RST 3'h0

// flash command cycles
`define FQ_QUERY_ADDR 32'h0000_0055
`define FQ_QUERY_CMD 8'h98
`define FQ_RESET_CMD 8'hf0
`define FQ_UNLOCK1_ADDR 32'h0000_0555
`define FQ_UNLOCK1_DATA 8'haa
`define FQ_UNLOCK2_ADDR 32'h0000_02aa
`define FQ_UNLOCK2_DATA 8'h55
`define FQ_AUTOSEL_CMD 8'h90
`define FQ_SUSPEND_CMD 8'hb0
`define FQ_RESUME_CMD 8'h30

// query table walk
`define FQ_QRY_FIRST 32'h0000_0027
`define FQ_CHK_LAST 6'h29

// flash status data bits
`define FQ_DQ_TOGGLE 6
`define FQ_DQ_TIMEOUT 5
`define FQ_DQ_BUFABORT 1

// timing
`define FQ_ADDR_W_DEF 25
`define FQ_CLK_MHZ 125
`define FQ_T_SU_NS 10
`define FQ_T_WP_NS 35
`define FQ_T_ACC_NS 120
`define FQ_T_HD_NS 10

`endif

// ---- fq_pkg.sv ----
// fq_pkg.sv - types shared by the flash query host controller
// assumes: fq_map.svh on the include path
package fq_pkg;
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_SETUP = 3'h1,
		S_STROBE = 3'h3,
		S_HOLD = 3'h2,
		S_NEXT = 3'h6
	} state_t;

	typedef enum logic [2:0] {
		OP_WR = 3'h0,
		OP_RD = 3'h1,
		OP_RST = 3'h2,
		OP_QRY = 3'h3,
		OP_CHK = 3'h4,
		OP_ABT = 3'h5,
		OP_POLL = 3'h6
	} op_t;

	typedef enum logic [1:0] {
		M_READ = 2'h0,
		M_SUSP = 2'h1,
		M_AUTOSEL = 2'h3,
		M_QUERY = 2'h2
	} mode_t;

	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
	} strobe_t;

	typedef struct packed {
		logic write;
		logic [31:0] addr;
		logic [15:0] data;
	} cyc_t;
endpackage

// ---- fq_flash_model.sv ----
// fq_flash_model.sv - behavioural nor flash: command decode, query table, fault status
// assumes: strobes come from the host's registers, sampled on its clock
`timescale 1ns/1ns
module fq_flash_model #(
	parameter int AW = 25
) (
	input wire logic clock,
	input wire fq_pkg::strobe_t flash_ctl,
	input wire logic [AW-1:0] flash_addr,
	input wire logic [15:0] flash_dq_o,
	output logic [15:0] flash_dq_i,
	input wire logic [1:0] fault,
	input wire logic fault_set,
	output fq_pkg::mode_t mode_q,
	output logic [AW-1:0] waddr_q,
	output logic [15:0] wdata_q,
	output logic [1:0] fault_q
);
	import fq_pkg::*;
	strobe_t prev_q;
	logic susp_q;
	logic tog_q;
	logic [15:0] rd_d;
	logic [15:0] last_q;
	function automatic logic [7:0] qval(input logic [7:0] a);
		case (a)
			8'h27: return 8'h18;
			8'h28, 8'h46, 8'h4c, 8'h30: return 8'h02;
			8'h2a: return 8'h05;
			8'h2c, 8'h47, 8'h50: return 8'h01;
			8'h2d: return 8'h7f;
			8'h40: return 8'h50;
			8'h41: return 8'h52;
			8'h42: return 8'h49;
			8'h43: return 8'h31;
			8'h44: return 8'h33;
			8'h45: return 8'h10;
			8'h49: return 8'h08;
			8'h4d: return 8'hb5;
			8'h4e: return 8'hc5;
			8'h4f: return 8'h04;
			default: return 8'h00;
		endcase
	endfunction
	initial begin
		prev_q = 3'b111;
		mode_q = M_READ;
		susp_q = 1'b0;
		tog_q = 1'b0;
		last_q = 16'h0;
		fault_q = 2'h0;
		waddr_q = '0;
		wdata_q = 16'h0;
	end
	// a busy part shows toggling status instead of data
	always_comb begin
		if (fault_q != 2'h0) rd_d = {9'h0, tog_q, fault_q == 2'h1, 3'h0, fault_q == 2'h2, 1'b0};
		else if (mode_q == M_QUERY) rd_d = {8'h00, qval(flash_addr[7:0])};
		else rd_d = ~flash_addr[15:0];
	end
	// released bus shows the inverse of the last word
	assign flash_dq_i = (!flash_ctl.ce_n && !flash_ctl.oe_n) ? rd_d : ~last_q;
	always @(posedge clock) begin
		prev_q <= flash_ctl;
		if (!flash_ctl.ce_n && !flash_ctl.oe_n) last_q <= rd_d;
		if (prev_q.oe_n && !flash_ctl.oe_n) tog_q <= !tog_q;
		if (fault_set) fault_q <= fault;
		if (prev_q.we_n && !flash_ctl.we_n && !flash_ctl.ce_n) waddr_q <= flash_addr;
		if (!prev_q.we_n && flash_ctl.we_n && !prev_q.ce_n) begin
			wdata_q <= flash_dq_o;
			case (flash_dq_o[7:0])
				8'hf0: begin
					mode_q <= susp_q ? M_SUSP : M_READ;
					fault_q <= 2'h0;
				end
				8'h98: if (waddr_q[7:0] == 8'h55 && mode_q inside {M_READ, M_AUTOSEL}) mode_q <= M_QUERY;
				8'h90: mode_q <= M_AUTOSEL;
				8'hb0: begin
					susp_q <= 1'b1;
					mode_q <= M_SUSP;
				end
				8'h30: begin
					susp_q <= 1'b0;
					mode_q <= M_READ;
				end
				default: ;
			endcase
		end
	end
endmodule // fq_flash_model

// ---- flash_query_host_tb.sv ----
// flash_query_host_tb.sv - register-driven scenarios against the flash model
// assumes: fq_map.svh on the include path, 125 MHz clock
`timescale 1ns/1ns
`include "fq_map.svh"
module flash_query_host_tb;
	import fq_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] sw_addr = 8'h00;
	logic [31:0] sw_wdata = 32'h0;
	logic sw_wr = 1'b0;
	logic sw_rd = 1'b0;
	logic [31:0] sw_rdata;
	strobe_t flash_ctl;
	logic [24:0] flash_addr;
	logic [15:0] flash_dq_o;
	logic flash_dq_oe;
	logic [15:0] flash_dq_i;
	logic [1:0] fault = 2'h0;
	logic fault_set = 1'b0;
	mode_t m_mode;
	logic [24:0] m_waddr;
	logic [15:0] m_wdata;
	logic [1:0] m_fault;
	logic [31:0] rv;
	int fail_count = 0;
	int check_count = 0;
	always #4 clock = ~clock;
	flash_query_host u_flash_query_host (.clock(clock), .rst_n(rst_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .flash_ctl(flash_ctl), .flash_addr(flash_addr),
		.flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe), .flash_dq_i(flash_dq_i));
	fq_flash_model u_fq_flash_model (.clock(clock), .flash_ctl(flash_ctl), .flash_addr(flash_addr),
		.flash_dq_o(flash_dq_o), .flash_dq_i(flash_dq_i), .fault(fault), .fault_set(fault_set),
		.mode_q(m_mode), .waddr_q(m_waddr), .wdata_q(m_wdata), .fault_q(m_fault));
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge clock);
		sw_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge clock);
		sw_rd <= 1'b0;
		#1 rv = sw_rdata;
	endtask
	// commands the host refuses are issued too; each op waits for busy to drop
	task automatic op(input logic [2:0] c);
		wr(`FQ_REG_CMD, {29'h0, c});
		for (int i = 0; i < 1000; i++) begin
			rd(`FQ_REG_STATUS);
			if (rv[`FQ_ST_BUSY] === 1'b0) break;
		end
		chk("busy", rv & 32'h1, 32'h0);
	endtask
	task automatic st(input logic [31:0] exp);
		rd(`FQ_REG_STATUS);
		chk("status", rv & 32'h1ff, exp);
	endtask
	task automatic t_reset();
		st(32'h0);
		rd(8'h1c);
		chk("unmapped", rv, 32'h0);
		chk("model mode", m_mode, M_READ);
	endtask
	task automatic t_query();
		op(3'h3);
		chk("model mode", m_mode, M_QUERY);
		st(32'h080);
		op(3'h4);
		st(32'h080);
		op(3'h3);
		st(32'h084);
		wr(`FQ_REG_STATUS, 32'h4);
	endtask
	task automatic t_mismatch();
		wr(`FQ_REG_CONFIG, 32'h2);
		op(3'h4);
		st(32'h082);
		rd(`FQ_REG_FAIL);
		chk("fail word", rv, 32'h002e_0000);
		wr(`FQ_REG_STATUS, 32'h2);
		wr(`FQ_REG_CONFIG, 32'h4);
		op(3'h4);
		st(32'h082);
		rd(`FQ_REG_FAIL);
		chk("fail word", rv, 32'h004f_0004);
		wr(`FQ_REG_STATUS, 32'h2);
		wr(`FQ_REG_CONFIG, 32'h0);
	endtask
	task automatic t_rst_cmd();
		wr(`FQ_REG_ADDR, 32'h123);
		op(3'h2);
		chk("model mode", m_mode, M_READ);
		chk("reset data", m_wdata, 16'h00f0);
		st(32'h0);
	endtask
	task automatic t_wr_rd();
		wr(`FQ_REG_ADDR, 32'h1234);
		wr(`FQ_REG_WDATA, 32'ha5);
		op(3'h0);
		chk("latched addr", m_waddr, 25'h1234);
		chk("latched data", m_wdata, 16'h00a5);
		chk("strobes idle", flash_ctl, 32'h7);
		chk("bus released", flash_dq_oe, 32'h0);
		op(3'h1);
		rd(`FQ_REG_RDATA);
		chk("array read", rv, 32'hedcb);
	endtask
	task automatic t_autosel();
		wr(`FQ_REG_WDATA, 32'h90);
		op(3'h0);
		st(32'h0c0);
		op(3'h3);
		chk("model mode", m_mode, M_QUERY);
		op(3'h2);
		chk("model mode", m_mode, M_READ);
	endtask
	task automatic t_suspend();
		wr(`FQ_REG_WDATA, 32'hb0);
		op(3'h0);
		st(32'h140);
		op(3'h3);
		st(32'h144);
		wr(`FQ_REG_STATUS, 32'h4);
		op(3'h2);
		chk("model mode", m_mode, M_SUSP);
		st(32'h140);
		wr(`FQ_REG_WDATA, 32'h30);
		op(3'h0);
		st(32'h020);
		op(3'h2);
		st(32'h024);
		chk("no reset sent", m_wdata, 16'h0030);
		wr(`FQ_REG_STATUS, 32'h4);
		op(3'h6);
		st(32'h0);
	endtask
	task automatic t_fault(input logic [1:0] f, input logic [31:0] flag);
		@(posedge clock);
		fault <= f;
		fault_set <= 1'b1;
		@(posedge clock);
		fault_set <= 1'b0;
		op(3'h6);
		rd(`FQ_REG_STATUS);
		chk("fault flag", rv & 32'h18, flag);
		chk("model fault", m_fault, 2'h0);
		chk("recovery data", m_wdata, 16'h00f0);
		wr(`FQ_REG_STATUS, 32'h18);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		t_reset();
		t_query();
		t_mismatch();
		t_rst_cmd();
		t_wr_rd();
		t_autosel();
		t_suspend();
		t_fault(2'h1, 32'h08);
		t_fault(2'h2, 32'h10);
		chk("abort addr", m_waddr, 25'h555);
		wrap_up();
	end
	initial begin
		#200000;
		fail_count++;
		wrap_up();
	end
endmodule // flash_query_host_tb
